// ===== hw/eeprom_pkg.sv
// Shared types, constants and decode helpers for the serial EEPROM slave logic
package eeprom_pkg;

  // Density codes: 0..4 select 128 to 2048 byte arrays
  localparam int unsigned  DENSITY_DEFAULT  = 4;
  localparam int unsigned  ADDR_W           = 11;
  localparam int unsigned  MEM_WORDS        = 2048;
  localparam int unsigned  PAGE_SLOTS       = 16;

  // Device type code in the top four address bits; value is arbitrary
  localparam logic [3:0]   DEV_TYPE_CODE    = 4'h5;

  // Programming cycle time and the clock it is counted on
  localparam int unsigned  PROG_TIME_MS     = 10;
  localparam int unsigned  CLK_HZ           = 200_000_000;
  localparam int unsigned  PROG_CYCLES      = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned  TIMER_W          = 24;

  // Bit counter and commit index limits
  localparam logic [3:0]   BITS_PER_BYTE    = 4'h8;
  localparam logic [4:0]   COMMIT_END       = 5'h10;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RX,
    ST_TX,
    ST_RACK
  } eng_state_e;

  typedef enum logic [1:0] {
    K_DEV,
    K_ADR,
    K_DAT
  } byte_kind_e;

  typedef struct packed {
    eng_state_e              st;
    byte_kind_e              kind;
    logic [3:0]              cnt;
    logic                    ack_slot;
    logic                    rw;
    logic                    mack;
    logic [2:0]              hi;
    logic [7:0]              shreg;
    logic [7:0]              tx;
    logic [ADDR_W-1:0]       ptr;
    logic [15:0][7:0]        pbuf;
    logic [15:0]             pvalid;
    logic                    busy;
    logic [4:0]              cidx;
    logic [TIMER_W-1:0]      timer;
    logic                    sda_drive;
  } eng_s;

  localparam eng_s ENG_RST = '{
    st: ST_IDLE, kind: K_DEV, cnt: 4'h0, ack_slot: 1'b0, rw: 1'b0, mack: 1'b0,
    hi: 3'h0, shreg: 8'h00, tx: 8'h00, ptr: 11'h000, pbuf: '0, pvalid: 16'h0000,
    busy: 1'b0, cidx: 5'h00, timer: 24'h000000, sda_drive: 1'b0};

  typedef struct packed {
    logic [1:0]              scl_s;
    logic [1:0]              sda_s;
    logic [1:0]              wp_s;
    logic [1:0][2:0]         cs_s;
    logic                    scl_q;
    logic                    sda_q;
  } mon_s;

  localparam mon_s MON_RST = '{
    scl_s: 2'h3, sda_s: 2'h3, wp_s: 2'h0, cs_s: '0, scl_q: 1'b1, sda_q: 1'b1};

  // Highest array address for a density
  function automatic logic [ADDR_W-1:0] last_addr(input int unsigned d);
    last_addr = ADDR_W'((32'h80 << d) - 1);
  endfunction

  // Page offset mask: 8 byte page on the smallest density, else 16
  function automatic logic [ADDR_W-1:0] page_mask(input int unsigned d);
    page_mask = (d == 0) ? 11'h007 : 11'h00F;
  endfunction

  // How many slave address bits carry upper array address bits
  function automatic int unsigned upper_bits(input int unsigned d);
    upper_bits = (d < 2) ? 0 : d - 1;
  endfunction

endpackage

// ===== hw/bus_cond_if.sv
// Synchronised bus levels and detected line events between monitor and engine
`timescale 1ns/10ps
interface bus_cond_if;
  logic        scl_rise;
  logic        scl_fall;
  logic        start;
  logic        stop;
  logic        sda;
  logic        wp;
  logic [2:0]  cs;

  modport mon (output scl_rise, scl_fall, start, stop, sda, wp, cs);
  modport eng (input  scl_rise, scl_fall, start, stop, sda, wp, cs);
endinterface

// ===== hw/bus_line_monitor.sv
// Pin synchroniser and START/STOP/edge detector for the two-wire bus
`timescale 1ns/10ps
module bus_line_monitor
(
  // Clock and control
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Raw pins
  input  wire logic        scl_pin,
  input  wire logic        sda_pin,
  input  wire logic        wp_pin,
  input  wire logic [2:0]  cs_pin,
  // Detected events
  bus_cond_if.mon          bus
);

  eeprom_pkg::mon_s r;
  eeprom_pkg::mon_s next_r;

  // Two stages per pin; only the second stage is looked at
  always_comb
  begin
    next_r       = r;
    next_r.scl_s = {r.scl_s[0], scl_pin};
    next_r.sda_s = {r.sda_s[0], sda_pin};
    next_r.wp_s  = {r.wp_s[0], wp_pin};
    next_r.cs_s  = {r.cs_s[0], cs_pin};
    next_r.scl_q = r.scl_s[1];
    next_r.sda_q = r.sda_s[1];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= eeprom_pkg::MON_RST;
    else if (ce)
      r <= next_r;
  end

  // Both lines share one delay, so START/STOP stay aligned to SCL
  assign bus.scl_rise = ce & r.scl_s[1] & ~r.scl_q;
  assign bus.scl_fall = ce & ~r.scl_s[1] & r.scl_q;
  assign bus.start    = ce & r.scl_s[1] & r.scl_q & r.sda_q & ~r.sda_s[1];
  assign bus.stop     = ce & r.scl_s[1] & r.scl_q & ~r.sda_q & r.sda_s[1];
  assign bus.sda      = r.sda_s[1];
  assign bus.wp       = r.wp_s[1];
  assign bus.cs       = r.cs_s[1];

endmodule

// ===== hw/serial_eeprom_access_logic.sv
// Slave command engine of a two-wire serial EEPROM with page buffer and array
`timescale 1ns/10ps

// Summary of operation
// - Byte write: write slave address, byte address, one data byte, each acknowledged.
// - The STOP closing a write starts the internal programming cycle.
// - During programming every bus request, own address included, gets no acknowledge.
// - Up to sixteen buffered bytes are committed in one programming cycle.
// - Each written data byte not refused by write protect is acknowledged and bumps only the page offset bits.
// - Excess page bytes wrap within the page and overwrite earlier ones.
// - STOP after a page write programs all buffered bytes together.
// - Slave address stays unacknowledged while programming still runs.
// - After programming ends a polling slave address is acknowledged again.
// - Write protect: addresses acknowledged, first data byte refused, nothing programmed.
// - Reads start like writes with direction bit one; three read forms.
// - Address counter holds last accessed address plus one.
// - Counter wraps from the last array address back to zero.
// - Current-address read returns one byte; master then withholds ack and stops.
// - After the repeated read address the byte at the given address is sent.
// - Each master acknowledge brings another byte from the next address.
// - Reads increment across the whole array address and wrap past the end.
// - Slave address: type code, chip-select or upper address bits, direction.
// - Programming lasts at most ten milliseconds from STOP; bus is disabled.
// - On a missing master acknowledge stop driving and wait for STOP.
module serial_eeprom_access_logic
#(
  parameter int unsigned DENSITY     = eeprom_pkg::DENSITY_DEFAULT,
  parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES
)
(
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Two-wire bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output wire logic        sda_out,
  output wire logic        sda_oe,
  // Straps
  input  wire logic        write_protect_input,
  input  wire logic [2:0]  chip_select_pins,
  // Status
  output wire logic        prog_busy
);

  localparam logic [eeprom_pkg::ADDR_W-1:0] LAST  = eeprom_pkg::last_addr(DENSITY);
  localparam logic [eeprom_pkg::ADDR_W-1:0] PMASK = eeprom_pkg::page_mask(DENSITY);
  localparam int unsigned                   UPB   = eeprom_pkg::upper_bits(DENSITY);
  localparam logic [eeprom_pkg::TIMER_W-1:0] PROG_LAST =
    eeprom_pkg::TIMER_W'(PROG_CYCLES - 1);

  bus_cond_if bus ();

  eeprom_pkg::eng_s r;
  eeprom_pkg::eng_s next_r;

  // Array storage; no reset, it models nonvolatile contents
  logic [7:0]                    mem [0:eeprom_pkg::MEM_WORDS-1];
  logic                          mem_we;
  logic [eeprom_pkg::ADDR_W-1:0] mem_addr;
  logic [7:0]                    mem_wd;
  logic [7:0]                    rd_byte;

  // Line synchroniser and event detector
  bus_line_monitor u_mon
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .scl_pin (scl_in),
    .sda_pin (sda_in),
    .wp_pin  (write_protect_input),
    .cs_pin  (chip_select_pins),
    .bus     (bus)
  );

  // Type code plus chip-select bits, upper address bits are free
  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] cs);
    logic ok;
    ok = (b[7:4] == eeprom_pkg::DEV_TYPE_CODE);
    for (int i = 0; i < 3; i++)
    begin
      if (i >= UPB && b[i+1] != cs[i])
        ok = 1'b0;
    end
    return ok;
  endfunction

  // Full-array increment used for reads
  function automatic logic [eeprom_pkg::ADDR_W-1:0] inc_full(
    input logic [eeprom_pkg::ADDR_W-1:0] a);
    return (a == LAST) ? '0 : a + 1'b1;
  endfunction

  // Upper address bits that the slave address byte may carry
  function automatic logic [2:0] upper_keep(input logic [2:0] h);
    logic [2:0] m;
    m = '0;
    for (int i = 0; i < 3; i++)
    begin
      if (i < UPB)
        m[i] = 1'b1;
    end
    return h & m;
  endfunction

  assign rd_byte = mem[r.ptr & LAST];

  // Engine next state
  always_comb
  begin
    logic                          load_rd;
    logic [eeprom_pkg::ADDR_W-1:0] nxt;
    load_rd  = 1'b0;
    nxt      = '0;
    next_r   = r;
    mem_we   = 1'b0;
    mem_addr = '0;
    mem_wd   = '0;
    if (r.busy)
    begin
      // Bus ignored entirely while programming, polling included
      next_r.st        = eeprom_pkg::ST_IDLE;
      next_r.sda_drive = 1'b0;
      next_r.ack_slot  = 1'b0;
      // One buffered byte per cycle, well inside the cycle time
      if (r.cidx != eeprom_pkg::COMMIT_END)
      begin
        mem_we      = r.pvalid[r.cidx[3:0]];
        mem_addr    = (r.ptr & ~PMASK) | (eeprom_pkg::ADDR_W'(r.cidx[3:0]) & PMASK);
        mem_wd      = r.pbuf[r.cidx[3:0]];
        next_r.cidx = r.cidx + 5'h01;
      end
      if (r.timer == PROG_LAST)
      begin
        next_r.busy   = 1'b0;
        next_r.pvalid = '0;
      end
      else
        next_r.timer = r.timer + 1'b1;
    end
    else if (bus.start)
    begin
      // Any START, repeated or not, begins a fresh address byte
      next_r.st        = eeprom_pkg::ST_RX;
      next_r.kind      = eeprom_pkg::K_DEV;
      next_r.cnt       = '0;
      next_r.ack_slot  = 1'b0;
      next_r.sda_drive = 1'b0;
    end
    else if (bus.stop)
    begin
      next_r.st        = eeprom_pkg::ST_IDLE;
      next_r.sda_drive = 1'b0;
      next_r.ack_slot  = 1'b0;
      if (|r.pvalid)
      begin
        next_r.busy  = 1'b1;
        next_r.timer = '0;
        next_r.cidx  = '0;
      end
    end
    else
    begin
      unique case (r.st)
        eeprom_pkg::ST_IDLE:
        begin
          next_r.sda_drive = 1'b0;
        end
        eeprom_pkg::ST_RX:
        begin
          if (bus.scl_rise && !r.ack_slot && r.cnt != eeprom_pkg::BITS_PER_BYTE)
          begin
            next_r.shreg = {r.shreg[6:0], bus.sda};
            next_r.cnt   = r.cnt + 4'h1;
          end
          else if (bus.scl_fall && r.ack_slot)
          begin
            // End of acknowledge clock: release and move on
            next_r.sda_drive = 1'b0;
            next_r.ack_slot  = 1'b0;
            next_r.cnt       = '0;
            if (r.kind == eeprom_pkg::K_DEV && r.rw)
              load_rd = 1'b1;
            else if (r.kind == eeprom_pkg::K_DEV)
              next_r.kind = eeprom_pkg::K_ADR;
            else
              next_r.kind = eeprom_pkg::K_DAT;
          end
          else if (bus.scl_fall && r.cnt == eeprom_pkg::BITS_PER_BYTE)
          begin
            unique case (r.kind)
              eeprom_pkg::K_DEV:
              begin
                if (addr_match(r.shreg, bus.cs))
                begin
                  next_r.rw        = r.shreg[0];
                  next_r.hi        = upper_keep(r.shreg[3:1]);
                  next_r.sda_drive = 1'b1;
                  next_r.ack_slot  = 1'b1;
                end
                else
                  next_r.st = eeprom_pkg::ST_IDLE;
              end
              eeprom_pkg::K_ADR:
              begin
                next_r.ptr       = {r.hi, r.shreg} & LAST;
                next_r.sda_drive = 1'b1;
                next_r.ack_slot  = 1'b1;
              end
              default:
              begin
                if (bus.wp)
                  next_r.st = eeprom_pkg::ST_IDLE;
                else
                begin
                  next_r.pbuf[r.ptr[3:0] & PMASK[3:0]]   = r.shreg;
                  next_r.pvalid[r.ptr[3:0] & PMASK[3:0]] = 1'b1;
                  next_r.ptr = (r.ptr & ~PMASK) | ((r.ptr + 1'b1) & PMASK);
                  next_r.sda_drive = 1'b1;
                  next_r.ack_slot  = 1'b1;
                end
              end
            endcase
          end
        end
        eeprom_pkg::ST_TX:
        begin
          if (bus.scl_fall)
          begin
            if (r.cnt != eeprom_pkg::BITS_PER_BYTE)
            begin
              next_r.sda_drive = ~r.tx[7];
              next_r.tx        = {r.tx[6:0], 1'b0};
              next_r.cnt       = r.cnt + 4'h1;
            end
            else
            begin
              // Last bit done: let the master answer
              next_r.sda_drive = 1'b0;
              next_r.st        = eeprom_pkg::ST_RACK;
            end
          end
        end
        eeprom_pkg::ST_RACK:
        begin
          if (bus.scl_rise)
            next_r.mack = ~bus.sda;
          else if (bus.scl_fall)
          begin
            if (r.mack)
              load_rd = 1'b1;
            else
              next_r.st = eeprom_pkg::ST_IDLE;
          end
        end
      endcase
    end
    // Start a byte out: first bit driven now, counter moves on
    if (load_rd)
    begin
      nxt              = inc_full(r.ptr);
      next_r.st        = eeprom_pkg::ST_TX;
      next_r.sda_drive = ~rd_byte[7];
      next_r.tx        = {rd_byte[6:0], 1'b0};
      next_r.cnt       = 4'h1;
      next_r.ptr       = nxt;
    end
  end

  // State register; the enable freezes everything
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= eeprom_pkg::ENG_RST;
    else if (ce)
      r <= next_r;
  end

  // Array write port
  always_ff @(posedge clk)
  begin
    if (ce && mem_we)
      mem[mem_addr & LAST] <= mem_wd;
  end

  // Open drain: only ever pulls low
  assign sda_out   = 1'b0;
  assign sda_oe    = r.sda_drive;
  assign prog_busy = r.busy;

endmodule

// ===== dv/serial_eeprom_access_logic_properties.sv
// Checker for the serial EEPROM slave ports, bound to the top module
`timescale 1ns/10ps
module serial_eeprom_access_checker
#(
  parameter int unsigned DENSITY     = 4,
  parameter int unsigned PROG_CYCLES = 200
)
(
  // Clock and control
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  // Bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Straps and status
  input wire logic       write_protect_input,
  input wire logic [2:0] chip_select_pins,
  input wire logic       prog_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic        sda_q;
  logic        idle;
  logic [3:0]  since_stop;
  logic [31:0] busy_cnt;
  wire         stop_ev = scl_in & sda_in & ~sda_q;
  wire         start_ev = scl_in & ~sda_in & sda_q;

  // Line events taken straight off the pins, ahead of the synchronisers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sda_q      <= 1'b1;
      idle       <= 1'b1;
      since_stop <= 4'hF;
      busy_cnt   <= 32'h0;
    end
    else
    begin
      sda_q      <= sda_in;
      idle       <= stop_ev | (idle & ~start_ev);
      since_stop <= stop_ev ? 4'h0 : since_stop + {3'h0, since_stop != 4'hF};
      busy_cnt   <= prog_busy ? busy_cnt + 32'h1 : 32'h0;
    end
  end

  busy_mute_a: assert property (prog_busy |-> !sda_oe)
    else $error("ack driven while programming");
  busy_cap_a: assert property (prog_busy |-> busy_cnt <= PROG_CYCLES + 1)
    else $error("programming runs too long");
  busy_len_a: assert property ($fell(prog_busy) |-> busy_cnt >= PROG_CYCLES - 1)
    else $error("programming ends too early");
  busy_cause_a: assert property ($rose(prog_busy) |-> since_stop < 4'hA)
    else $error("programming began without a stop");
  wp_guard_a: assert property ($rose(prog_busy) |-> !$past(write_protect_input, 8))
    else $error("programming under write protect");
  idle_quiet_a: assert property (idle |-> !sda_oe)
    else $error("data driven while bus idle");
  drive_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [* 8])
    else $error("low drive released too soon");

  // Main scenarios reached
  cover property ($rose(prog_busy));
  cover property ($fell(prog_busy));
  cover property (write_protect_input && sda_oe);
endmodule

bind serial_eeprom_access_logic serial_eeprom_access_checker
  #(.DENSITY(DENSITY), .PROG_CYCLES(PROG_CYCLES)) u_chk
  (.clk(clk), .rst_n(rst_n), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_input(write_protect_input),
   .chip_select_pins(chip_select_pins), .prog_busy(prog_busy));

// ===== dv/i2c_master_model.sv
// Two-wire bus master model that owns the clock line and all conditions
`timescale 1ns/10ps
module i2c_master_model
(
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda
);
  // Clock stands high between frames, data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Quarter of a 160 ns bus period
  task automatic q();
    repeat (8) @(posedge clk);
  endtask

  // Also serves as repeated start from a low clock
  task automatic start();
    sda <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask

  task automatic stop();
    sda <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda <= 1'b1;
    q();
  endtask

  // Nine bits MSB first; a one releases the line, sampled mid-high
  task automatic xfer(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      sda <= v[i];
      q();
      scl <= 1'b1;
      q();
      r[i] = sda_line;
      q();
      scl <= 1'b0;
      q();
    end
  endtask
endmodule

// ===== dv/serial_eeprom_access_logic_tb_top.sv
// Self-checking bench for the serial EEPROM slave command engine
`timescale 1ns/10ps
module serial_eeprom_access_logic_tb_top;
  localparam int unsigned PC = 600;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic        scl;
  logic        sda_m;
  logic        sda_oe;
  logic        sda_out;
  logic        wp;
  logic [2:0]  cs;
  logic        busy;
  wire         sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
  int          errors;
  int          checks_done;
  int          seed;
  logic [7:0]  mem [0:2047];
  logic [8:0]  r;
  logic [10:0] a;
  logic [10:0] p;

  serial_eeprom_access_logic #(.DENSITY(4), .PROG_CYCLES(PC)) DUT
  (.clk(clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda_line),
   .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_input(wp),
   .chip_select_pins(cs), .prog_busy(busy));

  i2c_master_model m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_m));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Slave address byte; upper array bits ride in the chip-select field
  function automatic logic [8:0] sadr(input logic [10:0] x, input logic rd);
    return {eeprom_pkg::DEV_TYPE_CODE, x[10:8], rd, 1'b1};
  endfunction

  // Only the page offset advances during a write
  function automatic logic [10:0] pnext(input logic [10:0] x);
    return {x[10:4], x[3:0] + 4'h1};
  endfunction

  // Write n bytes; nk is the line level expected in each data ack slot
  task automatic wr(input logic [10:0] x, input int n, input logic nk);
    logic [10:0] y;
    logic [7:0]  d;
    y = x;
    m.start();
    m.xfer(sadr(x, 1'b0), r);
    chk_bit("dev ack", 1'b0, r[0]);
    m.xfer({x[7:0], 1'b1}, r);
    chk_bit("adr ack", 1'b0, r[0]);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      m.xfer({d, 1'b1}, r);
      chk_bit("dat ack", nk, r[0]);
      if (nk)
        break;
      mem[y] = d;
      y = pnext(y);
    end
    m.stop();
    p = y;
  endtask

  task automatic poll(input logic nk);
    m.start();
    m.xfer(sadr(11'h000, 1'b0), r);
    chk_bit("poll ack", nk, r[0]);
    m.stop();
  endtask

  // Busy must follow the stop, refuse polls, then end within a bound
  task automatic wait_prog();
    int k;
    k = 0;
    chk_bit("busy", 1'b1, busy);
    poll(1'b1);
    while (busy === 1'b1 && k < 1000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 1000)
    begin
      errors++;
      summarize();
    end
    poll(1'b0);
    chk_bit("no prog", 1'b0, busy);
  endtask

  // Random read (dummy write first) or current-address read of n bytes
  task automatic rd(input logic [10:0] x, input logic rnd, input int n);
    if (rnd)
    begin
      m.start();
      m.xfer(sadr(x, 1'b0), r);
      m.xfer({x[7:0], 1'b1}, r);
      p = x;
    end
    m.start();
    m.xfer(sadr(x, 1'b1), r);
    chk_bit("rd ack", 1'b0, r[0]);
    for (int i = 0; i < n; i++)
    begin
      m.xfer({8'hFF, i == n - 1}, r);
      chk_byte("rd data", mem[p], r[8:1]);
      p = p + 11'h001;
    end
    m.stop();
  endtask

  initial
  begin
    seed = 3;
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    wp = 1'b0;
    cs = 3'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    // Freeze the engine briefly while the bus is idle
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    // Page write that runs past the page end and overwrites its start
    a = 11'($random(seed));
    a[3:0] = 4'hE;
    wr(a, 18, 1'b0);
    wait_prog();
    rd({a[10:4], 4'h0}, 1'b1, 15);
    rd(a, 1'b0, 1);
    $display("done: page write");
    // Random lengths and places
    repeat (2)
    begin
      a = 11'($random(seed));
      wr(a, 1 + ($random(seed) & 15), 1'b0);
      wait_prog();
      rd(a, 1'b1, 1);
    end
    $display("done: random writes");
    // Counter wrap at the last array address
    wr(11'h7FF, 1, 1'b0);
    wait_prog();
    wr(11'h000, 1, 1'b0);
    wait_prog();
    rd(11'h7FF, 1'b1, 2);
    $display("done: wrap");
    // Foreign type code must be left unanswered
    m.start();
    m.xfer({~eeprom_pkg::DEV_TYPE_CODE, 4'h0, 1'b1}, r);
    chk_bit("foreign ack", 1'b1, r[0]);
    m.stop();
    repeat (16) @(posedge clk);
    chk_bit("foreign busy", 1'b0, busy);
    $display("done: foreign address");
    // Write protect refuses the data and leaves the array alone
    wp <= 1'b1;
    cs <= 3'($random(seed));
    wr(11'h7FF, 1, 1'b1);
    repeat (16) @(posedge clk);
    chk_bit("wp busy", 1'b0, busy);
    wp <= 1'b0;
    rd(11'h7FF, 1'b1, 1);
    $display("done: write protect");
    summarize();
  end
endmodule
